// ==== src/tma_top.sv ====
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "tma_regs.svh"
module tma_top
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        t0_ovf,
   input  wire logic        external_count_input,
   input  wire logic [4:0]  module_io_pin_i,
   output logic      [4:0]  module_io_pin_o,
   output logic      [4:0]  module_io_pin_oe_n,
   output logic             irq,
   output logic             wdt_rst
);
   // ****************************************
   // decode helpers
   // ****************************************
   function automatic logic tma_mod_hit(input logic [7:0] a, input logic [3:0] slot, input logic [1:0] sub);
      return (a[7:4] == slot) && (a[3:2] == sub) && (a[1:0] == 2'h0);
   endfunction : tma_mod_hit
   function automatic logic tma_is_top(input logic [7:0] a);
      return (a == `TMA_OFF_CTRL) || (a == `TMA_OFF_COUNT) ||
             (a == `TMA_OFF_STAT) || (a == `TMA_OFF_MASK);
   endfunction : tma_is_top
   logic wr_acc;
   logic rd_acc;
   logic setup;
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign setup  = psel & ~penable;
   // ****************************************
   // pin synchronisers, bit 0 count pin
   // ****************************************
   logic [5:0] s1_ff;
   logic [5:0] s2_ff;
   logic [5:0] s3_ff;
   logic [5:0] lvl_ff;
   logic [5:0] nxt_lvl;
   logic [5:0] rise;
   logic [5:0] fall;
   // a level only moves once the last two stages agree
   always_comb
   begin
      nxt_lvl = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & lvl_ff);
      rise    = nxt_lvl & ~lvl_ff;
      fall    = ~nxt_lvl & lvl_ff;
   end
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_ff  <= `TMA_PIN_IDLE; // pulled-up idle, no false edge
         s2_ff  <= `TMA_PIN_IDLE;
         s3_ff  <= `TMA_PIN_IDLE;
         lvl_ff <= `TMA_PIN_IDLE;
      end
      else
      begin
         s1_ff  <= {module_io_pin_i, external_count_input};
         s2_ff  <= s1_ff;
         s3_ff  <= s2_ff;
         lvl_ff <= nxt_lvl;
      end
   end
   // ****************************************
   // time base
   // ****************************************
   tma_pkg::tma_ctrl_t ctrl_ff;
   tma_pkg::tma_ctrl_t nxt_ctrl;
   logic [15:0]        cnt_ff;
   logic [15:0]        nxt_cnt;
   logic [2:0]         div6_ff;
   logic [2:0]         nxt_div6;
   logic               div2_ff;
   logic               nxt_div2;
   logic               tick;
   logic               ovf;
   always_comb
   begin
      nxt_ctrl = ctrl_ff;
      nxt_cnt  = cnt_ff;
      nxt_div2 = ~div2_ff;
      nxt_div6 = (div6_ff == `TMA_DIV6_LAST) ? 3'h0 : div6_ff + 3'h1;
      case (ctrl_ff.src)
         tma_pkg::TMA_SRC_DIV6: tick = div6_ff == `TMA_DIV6_LAST;
         tma_pkg::TMA_SRC_DIV2: tick = div2_ff;
         tma_pkg::TMA_SRC_T0:   tick = t0_ovf;
         tma_pkg::TMA_SRC_EXT:  tick = fall[0];
         default:               tick = 1'b0;
      endcase
      tick = tick & ctrl_ff.run;
      ovf = tick && (cnt_ff == `TMA_CNT_MAX);
      if (tick)
         nxt_cnt = cnt_ff + 16'h0001;
      // software load wins over a count edge
      if (wr_acc && paddr == `TMA_OFF_COUNT)
         nxt_cnt = pwdata[15:0];
      if (wr_acc && paddr == `TMA_OFF_CTRL)
         nxt_ctrl = tma_pkg::tma_ctrl_t'(pwdata[`TMA_CTRL_W-1:0]);
   end
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_ff <= '0;
         cnt_ff  <= `TMA_RST_CNT;
         div6_ff <= 3'h0;
         div2_ff <= 1'b0;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         cnt_ff  <= nxt_cnt;
         div6_ff <= nxt_div6;
         div2_ff <= nxt_div2;
      end
   end
   // ****************************************
   // compare/capture modules
   // ****************************************
   logic [4:0]         evt;
   logic [4:0]         wdt_hit;
   tma_pkg::tma_mode_t mode_w [`TMA_NMOD];
   logic [7:0]         lo_w   [`TMA_NMOD];
   logic [7:0]         hi_w   [`TMA_NMOD];
   genvar gi;
   generate
      for (gi = 0; gi < `TMA_NMOD; gi++)
      begin : g_mod
         tma_pkg::tma_mode_t mode_ff;
         tma_pkg::tma_mode_t nxt_mode;
         logic [7:0]         lo_ff;
         logic [7:0]         nxt_lo;
         logic [7:0]         hi_ff;
         logic [7:0]         nxt_hi;
         logic [7:0]         duty_ff;
         logic [7:0]         nxt_duty;
         logic               out_ff;
         logic               nxt_out;
         logic               pwm_on;
         logic               cap;
         logic               match;
         logic [3:0]         slot;
         assign slot = 4'(gi + 1);
         always_comb
         begin
            nxt_mode = mode_ff;
            nxt_lo   = lo_ff;
            nxt_hi   = hi_ff;
            nxt_duty = duty_ff;
            nxt_out  = out_ff;
            pwm_on = mode_ff.pwm & mode_ff.ce;
            cap = (mode_ff.cap_pos & rise[gi+1]) | (mode_ff.cap_neg & fall[gi+1]);
            match = mode_ff.match & mode_ff.ce & tick & ~pwm_on &
                    (cnt_ff + 16'h0001 == {hi_ff, lo_ff});
            if (cap)
            begin
               nxt_lo = cnt_ff[7:0];
               nxt_hi = cnt_ff[15:8];
            end
            if (match && mode_ff.tog)
               nxt_out = ~out_ff;
            // duty reload on low byte wrap
            if (tick && cnt_ff[7:0] == `TMA_BYTE_MAX)
               nxt_duty = hi_ff;
            if (pwm_on)
               nxt_out = cnt_ff[7:0] >= duty_ff;
            if (wr_acc && tma_mod_hit(paddr, slot, `TMA_SUB_LO))
            begin
               nxt_lo      = pwdata[7:0];
               nxt_mode.ce = 1'b0;
            end
            if (wr_acc && tma_mod_hit(paddr, slot, `TMA_SUB_HI))
            begin
               nxt_hi      = pwdata[7:0];
               nxt_mode.ce = 1'b1;
            end
            if (wr_acc && tma_mod_hit(paddr, slot, `TMA_SUB_MODE))
               nxt_mode = tma_pkg::tma_mode_t'(pwdata[`TMA_MODE_W-1:0]);
            if (gi != `TMA_WDT_MOD)
               nxt_mode.wdt = 1'b0;
         end
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               mode_ff <= '0;
               lo_ff   <= `TMA_RST_BYTE;
               hi_ff   <= `TMA_RST_BYTE;
               duty_ff <= `TMA_RST_BYTE;
               out_ff  <= 1'b0;
            end
            else
            begin
               mode_ff <= nxt_mode;
               lo_ff   <= nxt_lo;
               hi_ff   <= nxt_hi;
               duty_ff <= nxt_duty;
               out_ff  <= nxt_out;
            end
         end
         assign evt[gi]                = cap | match;
         assign wdt_hit[gi]            = match & mode_ff.wdt;
         assign mode_w[gi]             = mode_ff;
         assign lo_w[gi]               = lo_ff;
         assign hi_w[gi]               = hi_ff;
         assign module_io_pin_o[gi]    = out_ff;
         // pin released unless module drives it
         assign module_io_pin_oe_n[gi] = ~(mode_ff.tog | pwm_on);
      end
   endgenerate
   // ****************************************
   // status, mask, interrupt, apb
   // ****************************************
   logic [5:0]  st_ff;
   logic [5:0]  nxt_st;
   logic [5:0]  mask_ff;
   logic [5:0]  nxt_mask;
   logic        irq_ff;
   logic        nxt_irq;
   logic        wdt_ff;
   logic        nxt_wdt;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic        err_ff;
   logic        nxt_err;
   logic [31:0] rdata;
   logic        hit;
   always_comb
   begin
      rdata = 32'h0000_0000;
      hit   = tma_is_top(paddr);
      case (paddr)
         `TMA_OFF_CTRL:  rdata[`TMA_CTRL_W-1:0] = ctrl_ff;
         `TMA_OFF_COUNT: rdata[15:0] = cnt_ff;
         `TMA_OFF_STAT:  rdata[`TMA_STAT_W-1:0] = st_ff;
         `TMA_OFF_MASK:  rdata[`TMA_STAT_W-1:0] = mask_ff;
         default:        rdata = 32'h0000_0000;
      endcase
      for (int i = 0; i < `TMA_NMOD; i++)
      begin
         if (tma_mod_hit(paddr, 4'(i + 1), `TMA_SUB_MODE))
         begin
            rdata[`TMA_MODE_W-1:0] = mode_w[i];
            hit = 1'b1;
         end
         if (tma_mod_hit(paddr, 4'(i + 1), `TMA_SUB_LO))
         begin
            rdata[7:0] = lo_w[i];
            hit = 1'b1;
         end
         if (tma_mod_hit(paddr, 4'(i + 1), `TMA_SUB_HI))
         begin
            rdata[7:0] = hi_w[i];
            hit = 1'b1;
         end
      end
      // read data and error latched in setup: one access cycle
      nxt_prdata = (setup && !pwrite) ? rdata : prdata_ff;
      nxt_err    = setup ? ~hit : err_ff;
      nxt_mask   = mask_ff;
      if (wr_acc && paddr == `TMA_OFF_MASK)
         nxt_mask = pwdata[`TMA_STAT_W-1:0];
      // clear only the bits software saw; a new event wins
      nxt_st = st_ff;
      if (rd_acc && paddr == `TMA_OFF_STAT)
         nxt_st = st_ff & ~prdata_ff[`TMA_STAT_W-1:0];
      nxt_st = nxt_st | {ovf, evt};
      nxt_irq = |(nxt_st & nxt_mask);
      nxt_wdt = wdt_hit[`TMA_WDT_MOD];
   end
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff     <= 6'h00;
         mask_ff   <= 6'h00;
         irq_ff    <= 1'b0;
         wdt_ff    <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         err_ff    <= 1'b0;
      end
      else
      begin
         st_ff     <= nxt_st;
         mask_ff   <= nxt_mask;
         irq_ff    <= nxt_irq;
         wdt_ff    <= nxt_wdt;
         prdata_ff <= nxt_prdata;
         err_ff    <= nxt_err;
      end
   end
   assign prdata  = prdata_ff;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & err_ff;
   assign irq     = irq_ff;
   assign wdt_rst = wdt_ff;
endmodule : tma_top

// ==== src/tma_regs.svh ====
`ifndef TMA_REGS_SVH
`define TMA_REGS_SVH
// ****************************************
// register map, byte addresses
// ****************************************
`define TMA_OFF_CTRL   8'h00
`define TMA_OFF_COUNT  8'h04
`define TMA_OFF_STAT   8'h08
`define TMA_OFF_MASK   8'h0C
`define TMA_SLOT_FIRST 4'h1
`define TMA_SLOT_LAST  4'h5
`define TMA_SUB_MODE   2'h0
`define TMA_SUB_LO     2'h1
`define TMA_SUB_HI     2'h2
// ****************************************
// fields, widths, reset values
// ****************************************
`define TMA_NMOD       5
`define TMA_WDT_MOD    4
`define TMA_OVF_BIT    5
`define TMA_STAT_W     6
`define TMA_MODE_W     7
`define TMA_CTRL_W     3
`define TMA_DIV6_LAST  3'h5
`define TMA_BYTE_MAX   8'hFF
`define TMA_CNT_MAX    16'hFFFF
`define TMA_RST_BYTE   8'h00
`define TMA_RST_CNT    16'h0000
`define TMA_PIN_IDLE   6'h3F
`endif

// ==== src/tma_pkg.sv ====
package tma_pkg;
   // count source select, gray along div6->div2->t0->ext
   typedef enum logic [1:0]
   {
      TMA_SRC_DIV6 = 2'h0,
      TMA_SRC_DIV2 = 2'h1,
      TMA_SRC_T0   = 2'h3,
      TMA_SRC_EXT  = 2'h2
   } tma_src_t;

   // counter mode register layout
   typedef struct packed
   {
      tma_src_t src;
      logic     run;
   } tma_ctrl_t;

   // module mode register layout, pwm at bit 0
   typedef struct packed
   {
      logic wdt;
      logic ce;
      logic cap_pos;
      logic cap_neg;
      logic match;
      logic tog;
      logic pwm;
   } tma_mode_t;
endpackage : tma_pkg

// ==== dv/tma_chk.sv ====
`timescale 1ns/10ps
// ********
// port checker
// ********
module tma_chk
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        t0_ovf,
   input wire logic        external_count_input,
   input wire logic [4:0]  module_io_pin_i,
   input wire logic [4:0]  module_io_pin_o,
   input wire logic [4:0]  module_io_pin_oe_n,
   input wire logic        irq,
   input wire logic        wdt_rst
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // write strobe, used by several checks
   wire wr = psel && penable && pwrite;
   chk_ready_always:
      assert property (pready) else $error("pready low");
   chk_err_phase:
      assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
   chk_bad_addr:
      assert property (psel && penable && !pwrite && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
      else $error("unaligned read not refused");
   chk_mask_off_irq:
      assert property (wr && paddr == 8'h0C && pwdata[5:0] == 6'h00 |-> ##2 !irq) else $error("masked irq");
   chk_pin_release:
      assert property (wr && paddr == 8'h10 && pwdata[1:0] == 2'h0 |-> ##2 module_io_pin_oe_n[0])
      else $error("pin not released");
   chk_pwm_drive:
      assert property (wr && paddr == 8'h10 && pwdata[0] && pwdata[5] |-> ##2 !module_io_pin_oe_n[0])
      else $error("pwm not driving");
   chk_pwm_gated:
      assert property (wr && paddr == 8'h10 && pwdata[5:0] == 6'h01 |-> ##2 module_io_pin_oe_n[0])
      else $error("pwm without enable drives");
   chk_wdt_single:
      assert property (wdt_rst |=> !wdt_rst) else $error("watchdog pulse too long");
   chk_reset_idle:
      assert property ($rose(rst_n) |-> module_io_pin_oe_n == 5'h1F && !irq) else $error("bad reset outputs");
   cover property (irq);
   cover property (wdt_rst);
   cover property (pslverr);
   cover property (!module_io_pin_oe_n[0]);
endmodule : tma_chk

bind tma_top tma_chk u_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
   .pslverr, .t0_ovf, .external_count_input, .module_io_pin_i, .module_io_pin_o, .module_io_pin_oe_n,
   .irq, .wdt_rst);

// ==== dv/tma_pin_model.sv ====
`timescale 1ns/10ps
// ********
// far side of the port pins
// ********
module tma_pin_model
(
   input  wire logic       ref_clk,
   input  wire logic [4:0] oe_n,
   input  wire logic [4:0] pin_o,
   output logic      [4:0] pin_i,
   output logic            ext_cnt,
   output logic            t0_ovf
);
   logic [4:0] far_drv;
   initial
   begin
      far_drv = 5'h1F;
      ext_cnt = 1'b1;
      t0_ovf = 1'b0;
   end
   // pull-up lines: module wins while it drives
   assign pin_i = (oe_n & far_drv) | (~oe_n & pin_o);
   // pulses held 3 cycles, beyond the filter
   task ext_pulses(input int n);
      repeat (n)
      begin
         @(posedge ref_clk) ext_cnt <= 1'b0;
         repeat (3) @(posedge ref_clk);
         ext_cnt <= 1'b1;
         repeat (3) @(posedge ref_clk);
      end
      repeat (6) @(posedge ref_clk);
   endtask : ext_pulses
   task t0_pulses(input int n);
      repeat (n)
      begin
         @(posedge ref_clk) t0_ovf <= 1'b1;
         @(posedge ref_clk) t0_ovf <= 1'b0;
      end
      repeat (2) @(posedge ref_clk);
   endtask : t0_pulses
   task drive(input int i, input logic v);
      @(posedge ref_clk) far_drv[i] <= v;
      repeat (8) @(posedge ref_clk);
   endtask : drive
endmodule : tma_pin_model

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
module testbench;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, q;
   logic        pready, pslverr, t0_ovf, ext_cnt, irq, wdt_rst, e, hs;
   logic        wdt_seen = 1'b0;
   logic [4:0]  pin_i, pin_o, oe_n;
   int          bad_count = 0;
   int          num_checks = 0;
   int          c;
   always #5 ref_clk = ~ref_clk;
   tma_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .t0_ovf(t0_ovf), .external_count_input(ext_cnt), .module_io_pin_i(pin_i),
      .module_io_pin_o(pin_o), .module_io_pin_oe_n(oe_n), .irq(irq), .wdt_rst(wdt_rst));
   tma_pin_model u_pins (.ref_clk(ref_clk), .oe_n(oe_n), .pin_o(pin_o), .pin_i(pin_i),
      .ext_cnt(ext_cnt), .t0_ovf(t0_ovf));
   // pulse is one cycle, so keep a sticky copy
   always @(posedge ref_clk)
      if (wdt_rst === 1'b1)
         wdt_seen <= 1'b1;
   task cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x)
      begin
         bad_count++;
         $display("BAD %s exp %h got %h", nm, x, g);
      end
   endtask : cmp
   // one apb transfer, held until pready is sampled
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      cmp($sformatf("reg %h", a), x, q);
   endtask : rd
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize
   // hang guard, far beyond the expected few hundred cycles
   initial
   begin
      #200000;
      bad_count++;
      summarize();
   end
   initial
   begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++)
         rd(8'(i * 4), 32'h0);
      apb(1'b0, 8'h0D, 32'h0);
      cmp("unaligned err", 32'h1, {31'h0, e});
      apb(1'b1, 8'hF0, 32'hFFFFFFFF);
      cmp("unmapped err", 32'h1, {31'h0, e});
      wr(8'h04, 32'hFFFE);
      wr(8'h00, 32'h5);
      u_pins.ext_pulses(3);
      wr(8'h00, 32'h4);
      rd(8'h04, 32'h1);
      rd(8'h08, 32'h20);
      rd(8'h08, 32'h0);
      wr(8'h00, 32'h7);
      u_pins.t0_pulses(4);
      wr(8'h00, 32'h6);
      rd(8'h04, 32'h5);
      for (int s = 0; s < 2; s++)
      begin
         wr(8'h04, 32'h0);
         wr(8'h00, 32'(s * 2 + 1));
         repeat (60) @(posedge ref_clk);
         wr(8'h00, 32'(s * 2));
         apb(1'b0, 8'h04, 32'h0);
         c = int'(q[15:0]) - (s == 1 ? 31 : 10);
         cmp("divided rate", 32'h1, {31'h0, (c >= -2 && c <= 2)});
      end
      wr(8'h10, 32'h20);
      wr(8'h14, 32'h40);
      rd(8'h10, 32'h0);
      wr(8'h18, 32'h80);
      rd(8'h10, 32'h20);
      wr(8'h10, 32'h01);
      wr(8'h04, 32'hFE);
      wr(8'h10, 32'h21);
      repeat (2) @(posedge ref_clk);
      cmp("pwm before reload", 32'h1, {31'h0, pin_o[0]});
      wr(8'h00, 32'h5);
      u_pins.ext_pulses(2);
      wr(8'h00, 32'h4);
      cmp("pwm after reload", 32'h0, {31'h0, pin_o[0]});
      wr(8'h04, 32'h190);
      repeat (2) @(posedge ref_clk);
      cmp("pwm at duty", 32'h1, {31'h0, pin_o[0]});
      wr(8'h10, 32'h0);
      repeat (2) @(posedge ref_clk);
      cmp("pin released", 32'h1, {31'h0, oe_n[0]});
      apb(1'b0, 8'h08, 32'h0);
      wr(8'h04, 32'h1234);
      wr(8'h0C, 32'h2);
      wr(8'h20, 32'h10);
      wr(8'h30, 32'h08);
      u_pins.drive(1, 1'b0);
      u_pins.drive(2, 1'b0);
      cmp("irq masked", 32'h0, {31'h0, irq});
      u_pins.drive(1, 1'b1);
      cmp("irq raised", 32'h1, {31'h0, irq});
      rd(8'h08, 32'h6);
      repeat (2) @(posedge ref_clk);
      cmp("irq cleared", 32'h0, {31'h0, irq});
      rd(8'h24, 32'h34);
      rd(8'h28, 32'h12);
      rd(8'h34, 32'h34);
      // fast output: toggle on match, then mask gates the request
      wr(8'h14, 32'h05);
      wr(8'h18, 32'h01);
      wr(8'h10, 32'h26);
      wr(8'h04, 32'h0104);
      hs = pin_o[0];
      wr(8'h00, 32'h5);
      u_pins.ext_pulses(1);
      wr(8'h00, 32'h4);
      cmp("fast output toggle", {31'h0, ~hs}, {31'h0, pin_o[0]});
      cmp("fast output drive", 32'h0, {31'h0, oe_n[0]});
      wr(8'h0C, 32'h01);
      repeat (2) @(posedge ref_clk);
      cmp("match irq", 32'h1, {31'h0, irq});
      wr(8'h0C, 32'h00);
      repeat (2) @(posedge ref_clk);
      cmp("irq mask off", 32'h0, {31'h0, irq});
      rd(8'h08, 32'h1);
      wr(8'h40, 32'h40);
      rd(8'h40, 32'h0);
      wr(8'h50, 32'h64);
      wr(8'h54, 32'h10);
      wr(8'h58, 32'h01);
      rd(8'h50, 32'h64);
      wr(8'h04, 32'h010F);
      wr(8'h00, 32'h5);
      cmp("watchdog idle", 32'h0, {31'h0, wdt_seen});
      u_pins.ext_pulses(1);
      cmp("watchdog pulse", 32'h1, {31'h0, wdt_seen});
      summarize();
   end
endmodule : testbench
